// >>> rtl/sunv_commit.sv
// Commit request held until the next serial clock rise
`timescale 1ns/1ps
`default_nettype none
`include "sunv_defs.svh"

module sunv_commit (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic host_set,
    input  wire logic op_set,
    input  wire logic sclk_rise,
    output logic      pending,
    output logic      fire
);

    logic pend_q;
    logic pend_d;

    // New request wins over the self-clear
    assign fire   = pend_q & sclk_rise;
    assign pend_d = host_set | op_set | (pend_q & ~fire);

    always_ff @(posedge core_clk) begin
        if (reset)
            pend_q <= 1'b0;
        else
            pend_q <= pend_d;
    end

    assign pending = pend_q;

endmodule
`default_nettype wire

// >>> rtl/sunv_defs.svh
// Constants for the sync, commit and nonvolatile loader block
// Behaviour
// - Anti-runt circuit enabled while control bit 3 is 0, disabled at 1.
// - Control bit 2 at 1 powers down the sync circuit.
// - Control bit 1 at 1 powers down the distribution reference.
// - Soft sync high holds channels static; its falling edge fires sync.
// - Writing 1 to commit bit copies buffers on next serial clock rise.
// - Commit bit clears itself once the copy is triggered.
// - Command list sits at 0xA00 to 0xAFF: start addresses and counts.
// - Command byte with bit 7 at 0 is a data-transfer entry.
// - Low seven bits of a transfer command give length minus one.
// - Two bytes after a transfer command hold start address, high first.
// - Command byte with bit 7 at 1 is one of two operation codes.
// - Commit operation code acts like the host writing 1 to commit bit.
// - End operation code stops the walk and ends the save or restore.
// - List resets to a default that moves all registers then commits.
// - Read-only busy flag is 1 while a transfer runs, else 0.
// - Save-start bit starts a save and clears itself when it finishes.
`ifndef SUNV_DEFS_SVH
`define SUNV_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SUNV_ADDR_CTRL      12'h230
`define SUNV_ADDR_COMMIT    12'h232
`define SUNV_ADDR_SEG_LO    12'hA00
`define SUNV_ADDR_SEG_HI    12'hAFF
`define SUNV_ADDR_BUSY      12'hB00
`define SUNV_ADDR_LOAD      12'hB02
`define SUNV_ADDR_SAVE      12'hB03

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SUNV_CTRL_RUNT_BIT  3
`define SUNV_CTRL_SPD_BIT   2
`define SUNV_CTRL_DPD_BIT   1
`define SUNV_CTRL_SOFT_BIT  0
`define SUNV_CTRL_WIDTH     4
`define SUNV_CTRL_RESET     4'h0
`define SUNV_LOAD_BIT       1
`define SUNV_CMD_OP_BIT     7

// ----------------------------------------
// Command list defaults and codes
// ----------------------------------------
`define SUNV_OP_COMMIT      8'h80
`define SUNV_OP_END         8'hFF
`define SUNV_DEF_CHUNKS     5
`define SUNV_DEF_LEN        8'h7F
`define SUNV_DEF_STEP       16'h0080
`define SUNV_SEG_DEPTH      256

`endif

// >>> rtl/sunv_pkg.sv
// Types shared by the loader block
package sunv_pkg;

    // Loader walk states, Gray in listed order; STEP to MOVE and FETCH to DONE flip two bits
    typedef enum logic [2:0] {
        SUNV_IDLE  = 3'b000,
        SUNV_FETCH = 3'b001,
        SUNV_ADRH  = 3'b011,
        SUNV_ADRL  = 3'b010,
        SUNV_MOVE  = 3'b110,
        SUNV_WAIT  = 3'b111,
        SUNV_STEP  = 3'b101,
        SUNV_DONE  = 3'b100
    } sunv_state_e;

    typedef logic [7:0] sunv_byte_t;

endpackage

// >>> rtl/sunv_segment.sv
// Command list storage with default contents
`timescale 1ns/1ps
`default_nettype none
`include "sunv_defs.svh"

module sunv_segment
    import sunv_pkg::*;
#(
    parameter sunv_byte_t OP_COMMIT = `SUNV_OP_COMMIT,
    parameter sunv_byte_t OP_END    = `SUNV_OP_END
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_idx,
    input  wire sunv_byte_t wr_data,
    input  wire logic [7:0] host_idx,
    output sunv_byte_t      host_data,
    input  wire logic [7:0] walk_idx,
    output sunv_byte_t      walk_data
);

    sunv_byte_t mem_q [`SUNV_SEG_DEPTH];

    // Default list: full chunks, then commit, then end codes
    function automatic sunv_byte_t def_byte(input int idx);
        logic [15:0] base;
        base = 16'((idx / 3) * `SUNV_DEF_STEP);
        if (idx < 3 * `SUNV_DEF_CHUNKS) begin
            if (idx % 3 == 0)
                return `SUNV_DEF_LEN;
            else if (idx % 3 == 1)
                return base[15:8];
            else
                return base[7:0];
        end else if (idx == 3 * `SUNV_DEF_CHUNKS)
            return OP_COMMIT;
        else
            return OP_END;
    endfunction

    // One flop byte per entry
    for (genvar i = 0; i < `SUNV_SEG_DEPTH; i++) begin : g_ent
        always_ff @(posedge core_clk) begin
            if (reset)
                mem_q[i] <= def_byte(i);
            else if (wr_en && wr_idx == 8'(i))
                mem_q[i] <= wr_data;
        end
    end

    assign host_data = mem_q[host_idx];
    assign walk_data = mem_q[walk_idx];

endmodule
`default_nettype wire

// >>> rtl/sunv_top.sv
// Sync control, commit strobe and command-list loader top
`timescale 1ns/1ps
`default_nettype none
`include "sunv_defs.svh"

module sunv_top
    import sunv_pkg::*;
#(
    parameter sunv_byte_t OP_COMMIT = `SUNV_OP_COMMIT,
    parameter sunv_byte_t OP_END    = `SUNV_OP_END
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        sclk_rise,
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             anti_runt_en,
    output logic             sync_pd,
    output logic             dist_ref_pd,
    output logic             sync_hold,
    output logic             sync_trigger,
    output logic             commit_pulse,
    output logic             xfer_busy,
    output logic      [15:0] rs_addr,
    output logic             rs_wr,
    output logic      [7:0]  rs_wdata,
    input  wire logic [7:0]  rs_rdata,
    output logic             nvm_req,
    output logic             nvm_we,
    output logic      [11:0] nvm_addr,
    output logic      [7:0]  nvm_wdata,
    input  wire logic [7:0]  nvm_rdata,
    input  wire logic        nvm_ack
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [`SUNV_CTRL_WIDTH-1:0] ctrl_buf_q;
    logic [`SUNV_CTRL_WIDTH-1:0] ctrl_act_q;
    logic [7:0]  rdata_q;
    logic        runt_en_q;
    logic        spd_q;
    logic        dpd_q;
    logic        hold_q;
    logic        trig_q;
    logic        cpulse_q;
    logic        busy_q;
    logic        save_q;
    logic        load_q;
    logic        dir_save_q;
    sunv_state_e state_q;
    sunv_state_e state_d;
    logic [7:0]  ptr_q;
    logic [6:0]  cnt_q;
    logic [7:0]  adrh_q;
    logic [15:0] rs_addr_q;
    logic        rs_wr_q;
    logic [7:0]  rs_wdata_q;
    logic        nvm_req_q;
    logic        nvm_we_q;
    logic [11:0] nvm_addr_q;
    logic [7:0]  nvm_wdata_q;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic       hit_ctrl;
    logic       hit_commit;
    logic       hit_seg;
    logic       hit_busy;
    logic       hit_load;
    logic       hit_save;
    logic       wr_ctrl;
    logic       wr_commit;
    logic       wr_seg;
    logic       wr_load;
    logic       wr_save;
    logic [7:0] seg_host;
    logic [7:0] seg_walk;
    logic [7:0] rd_mux;
    logic       commit_pend;
    logic       commit_fire;
    logic       op_commit;
    logic       walk_done;

    // Register selects
    assign hit_ctrl   = (reg_addr == `SUNV_ADDR_CTRL);
    assign hit_commit = (reg_addr == `SUNV_ADDR_COMMIT);
    assign hit_seg    = (reg_addr >= `SUNV_ADDR_SEG_LO) &&
                        (reg_addr <= `SUNV_ADDR_SEG_HI);
    assign hit_busy   = (reg_addr == `SUNV_ADDR_BUSY);
    assign hit_load   = (reg_addr == `SUNV_ADDR_LOAD);
    assign hit_save   = (reg_addr == `SUNV_ADDR_SAVE);

    // Write strobes
    assign wr_ctrl   = reg_wr & hit_ctrl;
    assign wr_commit = reg_wr & hit_commit & reg_wdata[0];
    assign wr_seg    = reg_wr & hit_seg;
    assign wr_load   = reg_wr & hit_load & reg_wdata[`SUNV_LOAD_BIT];
    assign wr_save   = reg_wr & hit_save & reg_wdata[0];

    // Read selection, unmapped and unused bits read zero
    always_comb begin
        if (hit_ctrl)
            rd_mux = {4'h0, ctrl_buf_q};
        else if (hit_commit)
            rd_mux = {7'h00, commit_pend};
        else if (hit_seg)
            rd_mux = seg_host;
        else if (hit_busy)
            rd_mux = {7'h00, busy_q};
        else if (hit_load)
            rd_mux = {6'h00, load_q, 1'b0};
        else if (hit_save)
            rd_mux = {7'h00, save_q};
        else
            rd_mux = 8'h00;
    end

    // ----------------------------------------
    // Command list and commit timing
    // ----------------------------------------
    sunv_segment #(.OP_COMMIT(OP_COMMIT), .OP_END(OP_END)) u_seg (
        .core_clk  (core_clk),
        .reset     (reset),
        .wr_en     (wr_seg),
        .wr_idx    (reg_addr[7:0]),
        .wr_data   (reg_wdata),
        .host_idx  (reg_addr[7:0]),
        .host_data (seg_host),
        .walk_idx  (ptr_q),
        .walk_data (seg_walk)
    );

    sunv_commit u_commit (
        .core_clk  (core_clk),
        .reset     (reset),
        .host_set  (wr_commit),
        .op_set    (op_commit),
        .sclk_rise (sclk_rise),
        .pending   (commit_pend),
        .fire      (commit_fire)
    );

    // ----------------------------------------
    // Host registers
    // ----------------------------------------
    // Host writes touch the buffer copy only
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_buf_q <= `SUNV_CTRL_RESET;
            ctrl_act_q <= `SUNV_CTRL_RESET;
        end else begin
            if (wr_ctrl)
                ctrl_buf_q <= reg_wdata[`SUNV_CTRL_WIDTH-1:0];
            if (commit_fire)
                ctrl_act_q <= ctrl_buf_q;
        end
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (reset)
            rdata_q <= 8'h00;
        else if (reg_rd)
            rdata_q <= rd_mux;
    end

    // Start bits: a new start wins over the finish clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            save_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            save_q <= wr_save | save_q & ~(walk_done & dir_save_q);
            load_q <= wr_load | (load_q & ~(walk_done & ~dir_save_q));
        end
    end

    // ----------------------------------------
    // Sync and power outputs from active copy, commit pulse from commit_fire
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            runt_en_q <= 1'b1;
            spd_q     <= 1'b0;
            dpd_q     <= 1'b0;
            hold_q    <= 1'b0;
            trig_q    <= 1'b0;
            cpulse_q  <= 1'b0;
        end else begin
            runt_en_q <= ~ctrl_act_q[`SUNV_CTRL_RUNT_BIT];
            spd_q     <= ctrl_act_q[`SUNV_CTRL_SPD_BIT];
            dpd_q     <= ctrl_act_q[`SUNV_CTRL_DPD_BIT];
            hold_q    <= ctrl_act_q[`SUNV_CTRL_SOFT_BIT];
            trig_q    <= hold_q & ~ctrl_act_q[`SUNV_CTRL_SOFT_BIT];
            cpulse_q  <= commit_fire;
        end
    end

    // ----------------------------------------
    // Loader walk
    // ----------------------------------------
    logic cmd_is_op;
    logic cmd_is_end;
    logic last_byte;

    assign cmd_is_op  = seg_walk[`SUNV_CMD_OP_BIT];
    assign cmd_is_end = cmd_is_op && (seg_walk == OP_END);
    assign op_commit  = (state_q == SUNV_FETCH) && cmd_is_op &&
                        (seg_walk == OP_COMMIT);
    assign last_byte  = (ptr_q == 8'hFF);
    assign walk_done  = (state_q == SUNV_DONE);

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            SUNV_IDLE: begin
                if (save_q || load_q)
                    state_d = SUNV_FETCH;
            end
            SUNV_FETCH: begin
                if (cmd_is_end || last_byte)
                    state_d = SUNV_DONE;
                else if (!cmd_is_op)
                    state_d = SUNV_ADRH;
            end
            SUNV_ADRH: state_d = SUNV_ADRL;
            SUNV_ADRL: state_d = SUNV_MOVE;
            SUNV_MOVE: state_d = SUNV_WAIT;
            SUNV_WAIT: begin
                if (nvm_ack)
                    state_d = SUNV_STEP;
            end
            SUNV_STEP: begin
                if (cnt_q == 7'h00)
                    state_d = SUNV_FETCH;
                else
                    state_d = SUNV_MOVE;
            end
            SUNV_DONE: state_d = SUNV_IDLE;
            default:   state_d = SUNV_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset)
            state_q <= SUNV_IDLE;
        else
            state_q <= state_d;
    end

    // List pointer, count and address capture
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ptr_q      <= 8'h00;
            cnt_q      <= 7'h00;
            adrh_q     <= 8'h00;
            rs_addr_q  <= 16'h0000;
            dir_save_q <= 1'b0;
        end else begin
            case (state_q)
                SUNV_IDLE: begin
                    ptr_q      <= 8'h00;
                    dir_save_q <= save_q;
                end
                SUNV_FETCH: begin
                    ptr_q <= ptr_q + 8'h01;
                    cnt_q <= seg_walk[6:0];
                end
                SUNV_ADRH: begin
                    ptr_q  <= ptr_q + 8'h01;
                    adrh_q <= seg_walk;
                end
                SUNV_ADRL: begin
                    ptr_q     <= ptr_q + 8'h01;
                    rs_addr_q <= {adrh_q, seg_walk};
                end
                SUNV_STEP: begin
                    if (cnt_q != 7'h00) begin
                        cnt_q     <= cnt_q - 7'h01;
                        rs_addr_q <= rs_addr_q + 16'h0001;
                    end
                end
                default: ;
            endcase
        end
    end

    // Storage and register-space handshakes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            nvm_req_q   <= 1'b0;
            nvm_we_q    <= 1'b0;
            nvm_addr_q  <= 12'h000;
            nvm_wdata_q <= 8'h00;
            rs_wr_q     <= 1'b0;
            rs_wdata_q  <= 8'h00;
            busy_q      <= 1'b0;
        end else begin
            rs_wr_q <= 1'b0;
            case (state_q)
                SUNV_IDLE: begin
                    nvm_addr_q <= 12'h000;
                    busy_q     <= save_q | load_q;
                end
                SUNV_MOVE: begin
                    nvm_req_q   <= 1'b1;
                    nvm_we_q    <= dir_save_q;
                    nvm_wdata_q <= rs_rdata;
                end
                SUNV_WAIT: begin
                    if (nvm_ack) begin
                        nvm_req_q  <= 1'b0;
                        nvm_addr_q <= nvm_addr_q + 12'h001;
                        rs_wr_q    <= ~dir_save_q;
                        rs_wdata_q <= nvm_rdata;
                    end
                end
                SUNV_DONE: busy_q <= 1'b0;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Output assignments
    // ----------------------------------------
    assign reg_rdata    = rdata_q;
    assign anti_runt_en = runt_en_q;
    assign sync_pd      = spd_q;
    assign dist_ref_pd  = dpd_q;
    assign sync_hold    = hold_q;
    assign sync_trigger = trig_q;
    assign commit_pulse = cpulse_q;
    assign xfer_busy    = busy_q;
    assign rs_addr      = rs_addr_q;
    assign rs_wr        = rs_wr_q;
    assign rs_wdata     = rs_wdata_q;
    assign nvm_req      = nvm_req_q;
    assign nvm_we       = nvm_we_q;
    assign nvm_addr     = nvm_addr_q;
    assign nvm_wdata    = nvm_wdata_q;

endmodule
`default_nettype wire

// >>> tb/sunv_checker.sv
// Assertions on the ports of the sync, commit and loader top
`timescale 1ns/1ps
`default_nettype none
module sunv_checker (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        sclk_rise,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        anti_runt_en,
    input wire logic        sync_pd,
    input wire logic        dist_ref_pd,
    input wire logic        sync_hold,
    input wire logic        sync_trigger,
    input wire logic        commit_pulse,
    input wire logic        xfer_busy,
    input wire logic        rs_wr,
    input wire logic [7:0]  rs_wdata,
    input wire logic        nvm_req,
    input wire logic        nvm_we,
    input wire logic [11:0] nvm_addr,
    input wire logic [7:0]  nvm_rdata,
    input wire logic        nvm_ack
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Host writes that start a commit or a save
    wire host_commit = reg_wr && reg_addr == 12'h232 && reg_wdata[0];
    wire save_go     = reg_wr && reg_addr == 12'hB03 && reg_wdata[0];

    // ----------------------------------------
    // Control outputs and commit
    // ----------------------------------------
    property p_ctrl_hold;
        !$past(commit_pulse) && !$past(reset) |->
            $stable({anti_runt_en, sync_pd, dist_ref_pd, sync_hold});
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control output moved without commit");
    property p_sync_fall;
        $fell(sync_hold) && !$past(reset) |-> sync_trigger;
    endproperty
    a_sync_fall: assert property (p_sync_fall)
        else $error("no sync trigger after hold fell");
    property p_commit_cause;
        commit_pulse |-> $past(sclk_rise);
    endproperty
    a_commit_cause: assert property (p_commit_cause)
        else $error("commit without serial clock rise");
    property p_commit_fire;
        host_commit ##1 sclk_rise |=> commit_pulse;
    endproperty
    a_commit_fire: assert property (p_commit_fire)
        else $error("host commit did not fire");

    // ----------------------------------------
    // Loader walk
    // ----------------------------------------
    property p_busy_req;
        nvm_req |-> xfer_busy;
    endproperty
    a_busy_req: assert property (p_busy_req)
        else $error("storage request while not busy");
    property p_save_start;
        save_go && !xfer_busy |-> ##[1:4] xfer_busy;
    endproperty
    a_save_start: assert property (p_save_start)
        else $error("save start did not raise busy");
    property p_nvm_step;
        nvm_req && nvm_ack |=>
            !nvm_req && nvm_addr == $past(nvm_addr) + 12'h001;
    endproperty
    a_nvm_step: assert property (p_nvm_step)
        else $error("storage address did not step");
    property p_restore_wr;
        rs_wr |-> $past(nvm_ack) && !$past(nvm_we) &&
            rs_wdata == $past(nvm_rdata);
    endproperty
    a_restore_wr: assert property (p_restore_wr)
        else $error("restore write not from storage data");
    // Main scenarios reached
    c_commit: cover property (commit_pulse);
    c_trigger: cover property (sync_trigger);
    c_restore: cover property (rs_wr);
endmodule

bind sunv_top sunv_checker u_chk (
    .core_clk(core_clk), .reset(reset), .sclk_rise(sclk_rise),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .anti_runt_en(anti_runt_en), .sync_pd(sync_pd),
    .dist_ref_pd(dist_ref_pd), .sync_hold(sync_hold),
    .sync_trigger(sync_trigger), .commit_pulse(commit_pulse),
    .xfer_busy(xfer_busy), .rs_wr(rs_wr), .rs_wdata(rs_wdata),
    .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
    .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack)
);
`default_nettype wire

// >>> tb/sunv_nvm_model.sv
// Storage and register space stand-in for the loader's far side
`timescale 1ns/1ps
`default_nettype none
module sunv_nvm_model (
    input  wire logic        core_clk,
    input  wire logic        slow,
    input  wire logic [15:0] rs_addr,
    input  wire logic        rs_wr,
    input  wire logic [7:0]  rs_wdata,
    output logic      [7:0]  rs_rdata,
    input  wire logic        nvm_req,
    input  wire logic        nvm_we,
    input  wire logic [11:0] nvm_addr,
    input  wire logic [7:0]  nvm_wdata,
    output logic      [7:0]  nvm_rdata,
    output logic             nvm_ack
);
    logic [7:0] regs [0:65535];
    logic [7:0] mem  [0:4095];
    logic [2:0] wait_q = 3'h0;
    // Register space reads straight from the address
    assign rs_rdata = regs[rs_addr];
    // Restored bytes land in register space
    always @(posedge core_clk) begin
        if (rs_wr)
            regs[rs_addr] <= rs_wdata;
    end
    // Storage answers late when slow; data line toggles when not answering
    initial begin
        nvm_ack = 1'b0;
        nvm_rdata = 8'h00;
    end
    always @(posedge core_clk) begin
        nvm_ack <= 1'b0;
        nvm_rdata <= ~nvm_rdata;
        if (nvm_req && !nvm_ack) begin
            if (wait_q >= (slow ? 3'h5 : 3'h0)) begin
                nvm_ack <= 1'b1;
                wait_q <= 3'h0;
                if (nvm_we)
                    mem[nvm_addr] <= nvm_wdata;
                else
                    nvm_rdata <= mem[nvm_addr];
            end else begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/sunv_top_tb.sv
// Self-checking bench for the sync, commit and loader top
`timescale 1ns/1ps
`default_nettype none
module sunv_top_tb;
    localparam logic [7:0] OPC = 8'h81;
    localparam logic [7:0] OPE = 8'hFE;
    localparam logic [7:0] LIST [11] = '{8'h01, 8'h12, 8'h34, 8'hFF, 8'h00,
        8'h00, 8'h40, OPE, 8'h00, 8'h00, 8'h50};
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        sclk_rise = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        slow = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata, rs_wdata, rs_rdata, nvm_wdata, nvm_rdata;
    logic [15:0] rs_addr;
    logic [11:0] nvm_addr;
    logic        anti_runt_en, sync_pd, dist_ref_pd, sync_hold;
    logic        sync_trigger, commit_pulse, xfer_busy;
    logic        rs_wr, nvm_req, nvm_we, nvm_ack;
    logic [7:0]  exp_q [$];
    int          errors = 0;
    int          n_tests = 0;

    // Non-default operation codes
    sunv_top #(.OP_COMMIT(OPC), .OP_END(OPE)) dut (
        .core_clk(core_clk), .reset(reset), .sclk_rise(sclk_rise),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .anti_runt_en(anti_runt_en), .sync_pd(sync_pd),
        .dist_ref_pd(dist_ref_pd), .sync_hold(sync_hold),
        .sync_trigger(sync_trigger), .commit_pulse(commit_pulse),
        .xfer_busy(xfer_busy), .rs_addr(rs_addr), .rs_wr(rs_wr),
        .rs_wdata(rs_wdata), .rs_rdata(rs_rdata), .nvm_req(nvm_req),
        .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack)
    );
    sunv_nvm_model u_mdl (
        .core_clk(core_clk), .slow(slow), .rs_addr(rs_addr), .rs_wr(rs_wr),
        .rs_wdata(rs_wdata), .rs_rdata(rs_rdata), .nvm_req(nvm_req),
        .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack)
    );

    // ----------------------------------------
    // Clock, checking and bus tasks
    // ----------------------------------------
    initial forever #50 core_clk = ~core_clk;
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic w, logic [11:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic sclk;
        @(posedge core_clk);
        sclk_rise <= 1'b1;
        @(posedge core_clk);
        sclk_rise <= 1'b0;
        #1;
    endtask
    task automatic wait_idle;
        int k = 0;
        while (xfer_busy !== 1'b0 && k < 20000) begin
            @(posedge core_clk);
            k++;
        end
        #1;
        check("walk ends", 16'(k < 20000), 16'h0001);
    endtask
    // Read data compared with the oldest noted expectation
    always @(posedge core_clk) begin
        if (reg_rd === 1'b1) begin
            #1;
            if (exp_q.size() == 0)
                check("read queue", 16'h0001, 16'h0000);
            else
                check("reg_rdata", 16'(reg_rdata), 16'(exp_q.pop_front()));
        end
    end
    // Hang guard
    initial begin
        repeat (40000) @(posedge core_clk);
        errors++;
        $display("timeout");
        give_verdict;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [7:0] v, old;
        void'($urandom(75));
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        check("anti_runt_en", 16'(anti_runt_en), 16'h0001);
        check("pd", 16'({sync_pd, dist_ref_pd, sync_hold}), 16'h0);
        rd(12'h230, 8'h00);
        for (int i = 0; i < 18; i++) begin
            v = (i % 3 == 0) ? 8'h7F : 8'((i % 3 == 1) ? i / 6 : i / 3 * 128);
            v = (i == 15) ? OPC : (i > 15) ? OPE : v;
            rd(12'hA00 + 12'(i), v);
        end
        rd(12'hAFF, OPE);
        bus(1'b1, 12'hB00, 8'hFF);
        rd(12'hB00, 8'h00);
        rd(12'h123, 8'h00);
        $display("test reset values done");
        old = 8'h00;
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom());
            v[0] = i[0];
            bus(1'b1, 12'h230, v);
            bus(1'b1, 12'h232, 8'h01);
            rd(12'h230, {4'h0, v[3:0]});
            rd(12'h232, 8'h01);
            check("held", 16'(sync_hold), 16'(old[0]));
            sclk;
            check("commit_pulse", 16'(commit_pulse), 16'h0001);
            @(posedge core_clk);
            #1;
            check("controls", 16'({anti_runt_en, sync_pd, dist_ref_pd,
                sync_hold}), 16'({~v[3],v[2:0]}));
            check("trigger", 16'({commit_pulse, sync_trigger}),
                16'({1'b0, old[0] & ~v[0]}));
            rd(12'h232, 8'h00);
            old = v;
        end
        $display("test control and commit done");
        for (int i = 0; i < 640; i++) u_mdl.regs[i] = 8'($urandom());
        bus(1'b1, 12'hB03, 8'h01);
        rd(12'hB00, 8'h01);
        rd(12'hB03, 8'h01);
        wait_idle;
        rd(12'hB03, 8'h00);
        rd(12'h232, 8'h01);
        sclk;
        check("loader commit", 16'(commit_pulse), 16'h0001);
        for (int i = 0; i < 640; i++) begin
            check("saved", 16'(u_mdl.mem[i]), 16'(u_mdl.regs[i]));
        end
        $display("test default save done");
        repeat (100) @(posedge core_clk);
        foreach (LIST[i]) bus(1'b1, 12'hA00 + 12'(i), LIST[i]);
        for (int i = 0; i < 3; i++) u_mdl.mem[i] = 8'($urandom());
        u_mdl.regs[16'h1236] = 8'h5A;
        u_mdl.regs[16'h0050] = 8'hA5;
        slow <= 1'b1;
        bus(1'b1, 12'hB02, 8'h02);
        repeat (3) @(posedge core_clk);
        wait_idle;
        check("r0", 16'(u_mdl.regs[16'h1234]), 16'(u_mdl.mem[0]));
        check("r1", 16'(u_mdl.regs[16'h1235]), 16'(u_mdl.mem[1]));
        check("r2", 16'(u_mdl.regs[16'h1236]), 16'h005A);
        check("r3", 16'(u_mdl.regs[16'h0040]), 16'(u_mdl.mem[2]));
        check("r4", 16'(u_mdl.regs[16'h0050]), 16'h00A5);
        $display("test restore list done");
        repeat (2) @(posedge core_clk);
        check("queue left", 16'(exp_q.size()), 16'h0000);
        give_verdict;
    end
endmodule
`default_nettype wire
